// ==== include/event_input_function_mapper_defs.vh ====
`ifndef EVENT_INPUT_FUNCTION_MAPPER_DEFS_VH
`define EVENT_INPUT_FUNCTION_MAPPER_DEFS_VH

// Clock and timing
`define CLK_KHZ 125000
`define T_ENTER_HOLD_MS 3000
`define T_RETURN_HOLD_MS 1000
`define T_IDLE_ACCEPT_MS 2000
`define T_DEBOUNCE_MS 10

// Register byte offsets
`define REG_FUNC_SEL 8'h00
`define REG_CONFIG 8'h04
`define REG_SP_UPPER 8'h08
`define REG_SP_LOWER 8'h0C
`define REG_FIXED_SP 8'h10
`define REG_RANGE_HI 8'h14
`define REG_RANGE_LO 8'h18
`define REG_STATUS 8'h1C
`define REG_LEVEL_MOVE 8'h20

// Config bits
`define CFG_DIR_BIT 0
`define CFG_LIM_RESET_BIT 1
`define CFG_RANGE_CHG_BIT 2

// Function codes
`define FN_NONE 4'h0
`define FN_INVERT 4'h1
`define FN_PROG_REMOTE 4'h2
`define FN_REMOTE_FIXED 4'h3
`define FN_PROG_FIXED 4'h4
`define FN_FULL_AT 4'h5
`define FN_PART_AT 4'h6
`define FN_LOCK 4'h7
`define FN_COMM_GATE 4'h8
`define FN_LATCH_CLR 4'h9
`define FN_WAIT 4'hA

// Input masks
`define MASK_IN12 4'h3
`define MASK_IN34 4'hC

// Set point sources
`define SRC_PROGRAM 2'h0
`define SRC_REMOTE 2'h1
`define SRC_FIXED 2'h2

// Levels
`define LVL_OPER 2'h0
`define LVL_INIT 2'h1
`define LVL_ADV 2'h2

// Values and widths
`define SP_W 16
`define PASSWORD 16'hFF57
`define RANGE_HI_RST 16'h7FFF
`define RANGE_LO_RST 16'h8000

`endif

// ==== hdl/event_input_function_mapper.v ====
// Contract
// - Invert function on input 1 or 2 flips configured control direction while ON.
// - Program/remote select uses remote SP while ON, program SP while OFF.
// - Remote SP indicator lit exactly while remote SP is active.
// - Remote/fixed select uses fixed SP while ON, remote SP while OFF.
// - Program/fixed select uses fixed SP while ON, program SP while OFF.
// - Fixed SP indicator lit exactly while fixed SP is active.
// - Full auto-tune starts on input ON edge, cancels on OFF edge.
// - Partial auto-tune starts on input ON edge, cancels on OFF edge.
// - Setting lock blocks setting changes while input ON.
// - Communications write gating accepted only on inputs 3 and 4.
// - Gated communications writes permitted while input ON, refused while OFF.
// - Latch clear clears alarm and heater latches on input ON edge.
// - Wait gating enables wait while input ON, disables while OFF.
// - Wait gating applies only while a program runs.
// - One function select per event input, writable at initial setting level.
// - Limit change pulls an out-of-range set point back inside.
// - Limiter reset forces out-of-range set point to nearer limit.
// - Input type or scaling change resets limits to the setting range.
// - Level key held three seconds moves operation to initial setting level.
// - Advanced level entered only with the fixed password in level-move.
// - Entered value accepted on mode key or two seconds without keys.
// - Level key held one second steps back one level.
//
// Decided for this implementation: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "event_input_function_mapper_defs.vh"

module event_input_function_mapper #(
  parameter [31:0] DEBOUNCE_CYC = `T_DEBOUNCE_MS * `CLK_KHZ,
  parameter [31:0] ENTER_HOLD_CYC = `T_ENTER_HOLD_MS * `CLK_KHZ,
  parameter [31:0] RETURN_HOLD_CYC = `T_RETURN_HOLD_MS * `CLK_KHZ,
  parameter [31:0] IDLE_ACCEPT_CYC = `T_IDLE_ACCEPT_MS * `CLK_KHZ
) (
  input wire clk_i,
  input wire reset_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire [3:0] event_i,
  input wire level_key_i,
  input wire mode_key_i,
  input wire program_running_i,
  input wire [`SP_W-1:0] program_setpoint_i,
  input wire [`SP_W-1:0] remote_setpoint_i,
  output reg direction_o,
  output reg [1:0] sp_source_o,
  output reg [`SP_W-1:0] active_sp_o,
  output reg remote_sp_ind_o,
  output reg fixed_sp_ind_o,
  output reg full_at_start_o,
  output reg full_at_cancel_o,
  output reg partial_at_start_o,
  output reg partial_at_cancel_o,
  output reg setting_lock_o,
  output reg comm_write_en_o,
  output reg latch_clear_o,
  output reg wait_enable_o,
  output reg [1:0] level_o
);

  function [3:0] fmatch;
    input [15:0] sel;
    input [3:0] code;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        fmatch[i] = (sel[i*4 +: 4] == code);
      end
    end
  endfunction

  function [`SP_W-1:0] clamp;
    input [`SP_W-1:0] v;
    input [`SP_W-1:0] hi;
    input [`SP_W-1:0] lo;
    begin
      if ($signed(v) > $signed(hi)) begin
        clamp = hi;
      end else if ($signed(v) < $signed(lo)) begin
        clamp = lo;
      end else begin
        clamp = v;
      end
    end
  endfunction

  // Debounce per input
  wire [3:0] deb_w;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_deb
      reg sync1_reg;
      reg sync2_reg;
      reg deb_reg;
      reg [31:0] cnt_reg;
      always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          sync1_reg <= 1'b0;
          sync2_reg <= 1'b0;
          deb_reg <= 1'b0;
          cnt_reg <= 32'h0000_0000;
        end else begin
          sync1_reg <= event_i[g];
          sync2_reg <= sync1_reg;
          if (sync2_reg == deb_reg) begin
            cnt_reg <= 32'h0000_0000;
          end else if (cnt_reg >= DEBOUNCE_CYC - 32'h0000_0001) begin
            deb_reg <= sync2_reg;
            cnt_reg <= 32'h0000_0000;
          end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
          end
        end
      end
      assign deb_w[g] = deb_reg;
    end
  endgenerate

  reg [3:0] deb_prev_reg;
  reg [15:0] func_sel_reg;
  reg cfg_dir_reg;
  reg [`SP_W-1:0] sp_upper_reg;
  reg [`SP_W-1:0] sp_lower_reg;
  reg [`SP_W-1:0] fixed_sp_reg;
  reg [`SP_W-1:0] range_hi_reg;
  reg [`SP_W-1:0] range_lo_reg;
  reg clamp_pend_reg;
  reg [`SP_W-1:0] level_move_reg;
  reg pass_pend_reg;
  reg [31:0] idle_cnt_reg;
  reg [31:0] hold_cnt_reg;
  reg hold_used_reg;
  reg mode_prev_reg;
  reg full_at_run_reg;
  reg part_at_run_reg;

  // Function activity from debounced contacts
  wire on_invert = |(fmatch(func_sel_reg, `FN_INVERT) & deb_w & `MASK_IN12);
  wire on_pr = |(fmatch(func_sel_reg, `FN_PROG_REMOTE) & deb_w & `MASK_IN12);
  wire on_rf = |(fmatch(func_sel_reg, `FN_REMOTE_FIXED) & deb_w & `MASK_IN12);
  wire on_pf = |(fmatch(func_sel_reg, `FN_PROG_FIXED) & deb_w & `MASK_IN12);
  wire as_rf = |(fmatch(func_sel_reg, `FN_REMOTE_FIXED) & `MASK_IN12);
  wire on_lock = |(fmatch(func_sel_reg, `FN_LOCK) & deb_w & `MASK_IN12);
  wire on_wait = |(fmatch(func_sel_reg, `FN_WAIT) & deb_w & `MASK_IN12);
  wire [3:0] m_full = fmatch(func_sel_reg, `FN_FULL_AT) & `MASK_IN12;
  wire [3:0] m_part = fmatch(func_sel_reg, `FN_PART_AT) & `MASK_IN12;
  wire [3:0] m_lat = fmatch(func_sel_reg, `FN_LATCH_CLR) & `MASK_IN12;
  wire [3:0] m_comm = fmatch(func_sel_reg, `FN_COMM_GATE) & `MASK_IN34;
  wire full_rise = |(m_full & deb_w & ~deb_prev_reg);
  wire full_fall = |(m_full & ~deb_w & deb_prev_reg);
  wire part_rise = |(m_part & deb_w & ~deb_prev_reg);
  wire part_fall = |(m_part & ~deb_w & deb_prev_reg);
  wire lat_rise = |(m_lat & deb_w & ~deb_prev_reg);
  // Writes allowed unless a gating input is assigned and all such are OFF
  wire comm_en = ~(|m_comm) | (|(m_comm & deb_w));

  reg [1:0] src_next;
  always @* begin
    src_next = `SRC_PROGRAM;
    if (|(fmatch(func_sel_reg, `FN_PROG_REMOTE) & `MASK_IN12)) begin
      src_next = on_pr ? `SRC_REMOTE : `SRC_PROGRAM;
    end else if (as_rf) begin
      src_next = on_rf ? `SRC_FIXED : `SRC_REMOTE;
    end else if (on_pf) begin
      src_next = `SRC_FIXED;
    end
  end

  // Wishbone slave
  wire req = cyc_i & stb_i & ~ack_o;
  wire wr = req & we_i & comm_en & (&sel_i[1:0]);
  wire wr_func = wr & (adr_i == `REG_FUNC_SEL) & (level_o == `LVL_INIT);
  wire wr_cfg = wr & (adr_i == `REG_CONFIG) & sel_i[0];
  wire wr_upper = wr & (adr_i == `REG_SP_UPPER);
  wire wr_lower = wr & (adr_i == `REG_SP_LOWER);
  wire wr_fixed = wr & (adr_i == `REG_FIXED_SP);
  wire wr_rhi = wr & (adr_i == `REG_RANGE_HI);
  wire wr_rlo = wr & (adr_i == `REG_RANGE_LO);
  wire wr_move = wr & (adr_i == `REG_LEVEL_MOVE) & (level_o == `LVL_INIT);
  wire range_chg = wr_cfg & dat_i[`CFG_RANGE_CHG_BIT];
  wire lim_reset = wr_cfg & dat_i[`CFG_LIM_RESET_BIT];

  reg [15:0] func_wr;
  integer k;
  always @* begin
    func_wr = dat_i[15:0];
    for (k = 0; k < 2; k = k + 1) begin
      if (dat_i[k*4 +: 4] == `FN_COMM_GATE) begin
        func_wr[k*4 +: 4] = `FN_NONE;
      end
    end
  end

  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h0000_0000;
    case (adr_i)
      `REG_FUNC_SEL: rd_next = {16'h0000, func_sel_reg};
      `REG_CONFIG: rd_next = {31'h0000_0000, cfg_dir_reg};
      `REG_SP_UPPER: rd_next = {16'h0000, sp_upper_reg};
      `REG_SP_LOWER: rd_next = {16'h0000, sp_lower_reg};
      `REG_FIXED_SP: rd_next = {16'h0000, fixed_sp_reg};
      `REG_RANGE_HI: rd_next = {16'h0000, range_hi_reg};
      `REG_RANGE_LO: rd_next = {16'h0000, range_lo_reg};
      `REG_STATUS: rd_next = {16'h0000, deb_w, level_o, wait_enable_o, comm_write_en_o,
        setting_lock_o, full_at_run_reg, part_at_run_reg, pass_pend_reg,
        sp_source_o, direction_o, 1'b0};
      `REG_LEVEL_MOVE: rd_next = {16'h0000, level_move_reg};
      default: rd_next = 32'h0000_0000;
    endcase
  end

  // Key timing and level moves
  wire key_any = level_key_i | mode_key_i;
  wire mode_rise = mode_key_i & ~mode_prev_reg;
  wire idle_done = pass_pend_reg & (idle_cnt_reg >= IDLE_ACCEPT_CYC - 32'h0000_0001);
  wire accept = pass_pend_reg & (mode_rise | idle_done);
  wire enter_hold = level_key_i & ~hold_used_reg &
    (hold_cnt_reg >= ENTER_HOLD_CYC - 32'h0000_0001);
  wire return_hold = level_key_i & ~hold_used_reg &
    (hold_cnt_reg >= RETURN_HOLD_CYC - 32'h0000_0001);

  reg [1:0] level_next;
  always @* begin
    level_next = level_o;
    case (level_o)
      `LVL_OPER: begin
        if (enter_hold) begin
          level_next = `LVL_INIT;
        end
      end
      `LVL_INIT: begin
        if (return_hold) begin
          level_next = `LVL_OPER;
        end else if (accept && level_move_reg == `PASSWORD) begin
          level_next = `LVL_ADV;
        end
      end
      `LVL_ADV: begin
        if (return_hold) begin
          level_next = `LVL_INIT;
        end
      end
      default: level_next = `LVL_OPER;
    endcase
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dat_o <= 32'h0000_0000;
      ack_o <= 1'b0;
      deb_prev_reg <= 4'h0;
      func_sel_reg <= 16'h0000;
      cfg_dir_reg <= 1'b0;
      sp_upper_reg <= `RANGE_HI_RST;
      sp_lower_reg <= `RANGE_LO_RST;
      fixed_sp_reg <= 16'h0000;
      range_hi_reg <= `RANGE_HI_RST;
      range_lo_reg <= `RANGE_LO_RST;
      clamp_pend_reg <= 1'b0;
      level_move_reg <= 16'h0000;
      pass_pend_reg <= 1'b0;
      idle_cnt_reg <= 32'h0000_0000;
      hold_cnt_reg <= 32'h0000_0000;
      hold_used_reg <= 1'b0;
      mode_prev_reg <= 1'b0;
      full_at_run_reg <= 1'b0;
      part_at_run_reg <= 1'b0;
      direction_o <= 1'b0;
      sp_source_o <= `SRC_PROGRAM;
      active_sp_o <= 16'h0000;
      remote_sp_ind_o <= 1'b0;
      fixed_sp_ind_o <= 1'b0;
      full_at_start_o <= 1'b0;
      full_at_cancel_o <= 1'b0;
      partial_at_start_o <= 1'b0;
      partial_at_cancel_o <= 1'b0;
      setting_lock_o <= 1'b0;
      comm_write_en_o <= 1'b1;
      latch_clear_o <= 1'b0;
      wait_enable_o <= 1'b0;
      level_o <= `LVL_OPER;
    end else begin
      ack_o <= req;
      dat_o <= req ? rd_next : 32'h0000_0000;
      deb_prev_reg <= deb_w;
      if (wr_func) begin
        func_sel_reg <= func_wr;
      end
      if (wr_cfg) begin
        cfg_dir_reg <= dat_i[`CFG_DIR_BIT];
      end
      if (wr_rhi) begin
        range_hi_reg <= dat_i[`SP_W-1:0];
      end
      if (wr_rlo) begin
        range_lo_reg <= dat_i[`SP_W-1:0];
      end
      // Limits and set point clamp
      if (range_chg) begin
        sp_upper_reg <= range_hi_reg;
        sp_lower_reg <= range_lo_reg;
      end else begin
        if (wr_upper) begin
          sp_upper_reg <= dat_i[`SP_W-1:0];
        end
        if (wr_lower) begin
          sp_lower_reg <= dat_i[`SP_W-1:0];
        end
      end
      clamp_pend_reg <= wr_upper | wr_lower | lim_reset | range_chg;
      if (wr_fixed) begin
        fixed_sp_reg <= clamp(dat_i[`SP_W-1:0], sp_upper_reg, sp_lower_reg);
      end else if (clamp_pend_reg) begin
        fixed_sp_reg <= clamp(fixed_sp_reg, sp_upper_reg, sp_lower_reg);
      end
      // Password entry
      mode_prev_reg <= mode_key_i;
      if (wr_move) begin
        level_move_reg <= dat_i[`SP_W-1:0];
        pass_pend_reg <= 1'b1;
        idle_cnt_reg <= 32'h0000_0000;
      end else if (accept || level_o != `LVL_INIT) begin
        pass_pend_reg <= 1'b0;
        idle_cnt_reg <= 32'h0000_0000;
      end else if (key_any) begin
        idle_cnt_reg <= 32'h0000_0000;
      end else if (pass_pend_reg) begin
        idle_cnt_reg <= idle_cnt_reg + 32'h0000_0001;
      end
      // Level key hold
      if (!level_key_i) begin
        hold_cnt_reg <= 32'h0000_0000;
        hold_used_reg <= 1'b0;
      end else begin
        hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
        if (level_next != level_o && !accept) begin
          hold_used_reg <= 1'b1;
        end
      end
      level_o <= level_next;
      // Function outputs
      direction_o <= cfg_dir_reg ^ on_invert;
      sp_source_o <= src_next;
      remote_sp_ind_o <= (src_next == `SRC_REMOTE);
      fixed_sp_ind_o <= (src_next == `SRC_FIXED);
      case (src_next)
        `SRC_REMOTE: active_sp_o <= remote_setpoint_i;
        `SRC_FIXED: active_sp_o <= fixed_sp_reg;
        default: active_sp_o <= program_setpoint_i;
      endcase
      full_at_start_o <= full_rise;
      full_at_cancel_o <= full_fall;
      partial_at_start_o <= part_rise;
      partial_at_cancel_o <= part_fall;
      if (full_rise) begin
        full_at_run_reg <= 1'b1;
      end else if (full_fall) begin
        full_at_run_reg <= 1'b0;
      end
      if (part_rise) begin
        part_at_run_reg <= 1'b1;
      end else if (part_fall) begin
        part_at_run_reg <= 1'b0;
      end
      setting_lock_o <= on_lock;
      comm_write_en_o <= comm_en;
      latch_clear_o <= lat_rise;
      wait_enable_o <= program_running_i & on_wait;
    end
  end

endmodule

`default_nettype wire

// ==== verification/event_input_function_mapper_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "event_input_function_mapper_defs.vh"
module event_mapper_checker #(
  parameter [31:0] ENTER_HOLD_CYC = 32'h0000_0028
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  input wire logic level_key_i,
  input wire logic program_running_i,
  input wire logic [1:0] sp_source_o,
  input wire logic remote_sp_ind_o,
  input wire logic fixed_sp_ind_o,
  input wire logic full_at_start_o,
  input wire logic full_at_cancel_o,
  input wire logic partial_at_start_o,
  input wire logic partial_at_cancel_o,
  input wire logic wait_enable_o,
  input wire logic [1:0] level_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic [31:0] hold_cnt_reg;
  // Cycles the level key has been held
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hold_cnt_reg <= '0;
    end else begin
      hold_cnt_reg <= level_key_i ? hold_cnt_reg + 32'h0000_0001 : '0;
    end
  end
  a_ack_next_cycle: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack after request");
  a_ack_one_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_read_data_idle: assert property (!ack_o |-> dat_o == '0)
    else $error("read data outside ack");
  a_remote_ind_exact: assert property (remote_sp_ind_o == (sp_source_o == `SRC_REMOTE))
    else $error("remote indicator wrong");
  a_fixed_ind_exact: assert property (fixed_sp_ind_o == (sp_source_o == `SRC_FIXED))
    else $error("fixed indicator wrong");
  a_wait_needs_program: assert property (!program_running_i && !$past(program_running_i)
    |-> !wait_enable_o)
    else $error("wait enabled without program");
  a_tune_start_pulse: assert property (full_at_start_o |=> !full_at_start_o)
    else $error("tune start not a pulse");
  a_tune_start_cancel: assert property (!(full_at_start_o && full_at_cancel_o)
    && !(partial_at_start_o && partial_at_cancel_o))
    else $error("tune start and cancel together");
  a_level_one_step: assert property ((level_o != $past(level_o))
    |-> (level_o == `LVL_INIT || $past(level_o) == `LVL_INIT))
    else $error("level skipped a step");
  a_level_enter_hold: assert property (level_o == `LVL_INIT && $past(level_o) == `LVL_OPER
    |-> hold_cnt_reg >= ENTER_HOLD_CYC - 32'h0000_0001)
    else $error("initial level entered too early");
endmodule
bind event_input_function_mapper event_mapper_checker #(.ENTER_HOLD_CYC(ENTER_HOLD_CYC))
  i_props (.clk_i, .reset_i, .cyc_i, .stb_i, .ack_o, .dat_o, .level_key_i, .program_running_i,
  .sp_source_o, .remote_sp_ind_o, .fixed_sp_ind_o, .full_at_start_o, .full_at_cancel_o,
  .partial_at_start_o, .partial_at_cancel_o, .wait_enable_o, .level_o);
`default_nettype wire

// ==== verification/contact_panel_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module contact_panel_model (
  input wire logic clk_i,
  input wire logic [3:0] want_i,
  output logic [3:0] event_o
);
  logic [3:0] prev = '0;
  logic [3:0] mask = '0;
  logic [1:0] n = '0;
  initial event_o = '0;
  // Each change chatters three edges before it settles
  always @(posedge clk_i) begin
    if (n != 2'h0) begin
      event_o <= event_o ^ mask;
      n <= n - 2'h1;
    end else if (want_i != prev) begin
      mask <= want_i ^ prev;
      prev <= want_i;
      event_o <= event_o ^ want_i ^ prev;
      n <= 2'h2;
    end
  end
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "event_input_function_mapper_defs.vh"
module testbench;
  localparam int DB = 4, EH = 40, RH = 20, IA = 30;
  logic clk_i = 0, reset_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic level_key_i = 0, mode_key_i = 0, program_running_i = 0;
  logic [7:0] adr_i = '0;
  logic [3:0] sel_i = '0, want = '0;
  logic [31:0] dat_i = '0, rd;
  logic [15:0] program_setpoint_i = 16'h0011, remote_setpoint_i = 16'h0022;
  wire [31:0] dat_o;
  wire [3:0] event_i;
  wire [1:0] sp_source_o, level_o;
  wire [15:0] active_sp_o;
  wire ack_o, direction_o, remote_sp_ind_o, fixed_sp_ind_o, full_at_start_o, full_at_cancel_o;
  wire partial_at_start_o, partial_at_cancel_o, setting_lock_o, comm_write_en_o;
  wire latch_clear_o, wait_enable_o;
  wire [4:0] pv = {latch_clear_o, partial_at_cancel_o, partial_at_start_o, full_at_cancel_o,
    full_at_start_o};
  logic [4:0][7:0] pc = '0, p0;
  logic [3:0] codes [8] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hA};
  logic [3:0] c;
  int err_count = 0, n_checks = 0, cycles = 0;
  always #4 clk_i = ~clk_i;
  event_input_function_mapper #(.DEBOUNCE_CYC(DB), .ENTER_HOLD_CYC(EH),
    .RETURN_HOLD_CYC(RH), .IDLE_ACCEPT_CYC(IA)) i_dut (.clk_i, .reset_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .event_i, .level_key_i, .mode_key_i,
    .program_running_i, .program_setpoint_i, .remote_setpoint_i, .direction_o, .sp_source_o,
    .active_sp_o, .remote_sp_ind_o, .fixed_sp_ind_o, .full_at_start_o, .full_at_cancel_o,
    .partial_at_start_o, .partial_at_cancel_o, .setting_lock_o, .comm_write_en_o,
    .latch_clear_o, .wait_enable_o, .level_o);
  contact_panel_model i_panel (.clk_i(clk_i), .want_i(want), .event_o(event_i));
  always @(posedge clk_i) begin
    for (int i = 0; i < 5; i++) pc[i] <= pc[i] + pv[i];
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, 4'hF};
    do @(posedge clk_i); while (ack_o !== 1'h1);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'h0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'h0, a, '0);
    chk(rd, exp);
  endtask
  task automatic put(input logic [3:0] v);
    @(posedge clk_i);
    want <= v;
    repeat (16) @(posedge clk_i);
  endtask
  task automatic keyhold(input int n);
    @(posedge clk_i);
    level_key_i <= 1'h1;
    repeat (n) @(posedge clk_i);
    level_key_i <= 1'h0;
    repeat (4) @(posedge clk_i);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'h0;
    @(posedge clk_i);
    chk(comm_write_en_o, 1);
    rdchk(8'h40, 0);
    rdchk(`REG_SP_UPPER, {16'h0000, `RANGE_HI_RST});
    keyhold(EH - 5);
    chk(level_o, `LVL_OPER);
    keyhold(EH + 5);
    chk(level_o, `LVL_INIT);
    wb(1'h1, `REG_FUNC_SEL, 32'h0000_0008);
    rdchk(`REG_FUNC_SEL, 0);
    put(4'h4);
    wb(1'h1, `REG_FUNC_SEL, 32'h0000_0821);
    rdchk(`REG_FUNC_SEL, 32'h0000_0821);
    put(4'h5);
    chk(direction_o, 1);
    wb(1'h1, `REG_CONFIG, 32'h0000_0001);
    repeat (3) @(posedge clk_i);
    chk(direction_o, 0);
    put(4'h6);
    chk(direction_o, 1);
    chk(sp_source_o, `SRC_REMOTE);
    chk(active_sp_o, remote_setpoint_i);
    chk(remote_sp_ind_o, 1);
    put(4'h4);
    chk(active_sp_o, program_setpoint_i);
    chk(remote_sp_ind_o, 0);
    put(4'h0);
    chk(comm_write_en_o, 0);
    wb(1'h1, `REG_FIXED_SP, 32'h0000_0033);
    put(4'h4);
    chk(comm_write_en_o, 1);
    rdchk(`REG_FIXED_SP, 0);
    wb(1'h1, `REG_FIXED_SP, 32'h0000_00C8);
    for (int i = 0; i < 8; i++) begin
      c = codes[i];
      wb(1'h1, `REG_FUNC_SEL, {28'h000_0080, c});
      program_running_i <= (i == 7);
      p0 = pc;
      put(4'h5);
      chk(sp_source_o, (c == 3 || c == 4) ? `SRC_FIXED : `SRC_PROGRAM);
      chk(fixed_sp_ind_o, c == 3 || c == 4);
      chk(active_sp_o, (c == 3 || c == 4) ? 16'h00C8 : program_setpoint_i);
      chk(setting_lock_o, c == 7);
      chk(wait_enable_o, c == 10 && i == 7);
      put(4'h4);
      chk(sp_source_o, (c == 3) ? `SRC_REMOTE : `SRC_PROGRAM);
      chk(remote_sp_ind_o, c == 3);
      chk(setting_lock_o, 0);
      chk(wait_enable_o, 0);
      for (int k = 0; k < 5; k++) begin
        chk(pc[k] - p0[k], (k < 2) ? c == 5 : (k < 4) ? c == 6 : c == 9);
      end
    end
    wb(1'h1, `REG_SP_UPPER, 32'h0000_0064);
    repeat (3) @(posedge clk_i);
    rdchk(`REG_FIXED_SP, 32'h0000_0064);
    wb(1'h1, `REG_RANGE_LO, 32'h0000_0000);
    wb(1'h1, `REG_RANGE_HI, 32'h0000_01F4);
    wb(1'h1, `REG_CONFIG, 32'h0000_0004);
    rdchk(`REG_SP_UPPER, 32'h0000_01F4);
    rdchk(`REG_SP_LOWER, 0);
    wb(1'h1, `REG_LEVEL_MOVE, 32'h0000_0001);
    @(posedge clk_i);
    mode_key_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    mode_key_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    chk(level_o, `LVL_INIT);
    rdchk(`REG_STATUS, 32'h0000_4500);
    wb(1'h1, `REG_LEVEL_MOVE, {16'h0000, `PASSWORD});
    repeat (IA - 5) @(posedge clk_i);
    chk(level_o, `LVL_INIT);
    repeat (10) @(posedge clk_i);
    chk(level_o, `LVL_ADV);
    keyhold(RH + 5);
    chk(level_o, `LVL_INIT);
    keyhold(RH - 5);
    chk(level_o, `LVL_INIT);
    keyhold(RH + 5);
    chk(level_o, `LVL_OPER);
    wb(1'h1, `REG_FUNC_SEL, 32'h0000_0007);
    rdchk(`REG_FUNC_SEL, 32'h0000_080A);
    print_verdict();
  end
endmodule
`default_nettype wire
